// file: logic/flash_rd_pkg.sv
// Shared constants and types for the serial flash read-side command link
package flash_rd_pkg;
    // ============================================================
    // Organisation
    localparam int unsigned PAGE_COUNT       = 512;
    localparam int unsigned BYTES_PER_PAGE   = 264;
    localparam int unsigned ARRAY_BYTES      = PAGE_COUNT * BYTES_PER_PAGE;
    localparam logic [8:0]  LAST_BYTE        = 9'h107;
    localparam logic [8:0]  FIRST_BYTE       = 9'h000;

    // ============================================================
    // Opcodes
    localparam logic [7:0]  OP_PAGE_READ     = 8'h52;
    localparam logic [7:0]  OP_BUF_READ      = 8'h54;
    localparam logic [7:0]  OP_PAGE_TO_BUF   = 8'h53;
    localparam logic [7:0]  OP_PAGE_CMP      = 8'h60;
    localparam logic [7:0]  OP_STATUS_READ   = 8'h57;

    // ============================================================
    // Frame field lengths and positions
    localparam logic [5:0]  OPCODE_BITS      = 6'h08;
    localparam logic [5:0]  ADDR_BITS        = 6'h18;
    localparam logic [5:0]  PAGE_READ_DUMMY  = 6'h20;
    localparam logic [5:0]  BUF_READ_DUMMY   = 6'h08;
    localparam int unsigned PAGE_FIELD_LSB   = 9;
    localparam int unsigned BYTE_FIELD_LSB   = 0;

    // ============================================================
    // Status byte layout
    localparam int unsigned STAT_READY_BIT   = 7;
    localparam int unsigned STAT_CMP_BIT     = 6;
    localparam logic [3:0]  DENSITY_CODE     = 4'h0;    // Arbitrary value
    localparam logic        CMP_RESET        = 1'b0;

    // ============================================================
    // Timing at 50 MHz core clock
    localparam int unsigned CORE_CLK_PERIOD_NS     = 20;
    localparam int unsigned PAGE_TRANSFER_TIME_NS  = 10560;
    localparam int unsigned PAGE_TRANSFER_CYC      = PAGE_TRANSFER_TIME_NS / CORE_CLK_PERIOD_NS;
    localparam int unsigned SCK_HALF_TIME_NS       = 160;
    localparam int unsigned SCK_HALF_CYC           = SCK_HALF_TIME_NS / CORE_CLK_PERIOD_NS;

    // ============================================================
    // Device frame phases, background engine states and host sequencer states
    typedef enum logic [5:0] {
        PH_OPCODE = 6'b000001,
        PH_ADDR   = 6'b000010,
        PH_DUMMY  = 6'b000100,
        PH_DATA   = 6'b001000,
        PH_STATUS = 6'b010000,
        PH_IGNORE = 6'b100000
    } frame_phase_t;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_COPY = 3'b010,
        ENG_CMP  = 3'b100
    } engine_state_t;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b001,
        HS_RUN    = 3'b010,
        HS_FINISH = 3'b100
    } host_state_t;

    // Flat storage index of a byte within a page
    function automatic logic [17:0] mem_index(input logic [8:0] page, input logic [8:0] offset);
        logic [26:0] full;
        full = 27'(page) * 27'(BYTES_PER_PAGE) + 27'(offset);
        return full[17:0];
    endfunction : mem_index
endpackage : flash_rd_pkg

// file: logic/flash_spi_if.sv
// Serial link between the flash device end and the host end
`timescale 1ns/10ps
interface flash_spi_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_drv;
    logic so_oe;
    logic so;

    // Undriven output line floats high through a pull-up
    assign so = so_oe ? so_drv : 1'b1;

    modport dev (input cs_n, input sck, input si, output so_drv, output so_oe);
    modport host (output cs_n, output sck, output si, input so);
endinterface : flash_spi_if

// file: logic/flash_rd_device.sv
// Flash device end: read, buffer read, page-to-buffer transfer and compare
// ============================================================
`timescale 1ns/10ps
module flash_rd_device (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    flash_spi_if.dev         spi,
    input  wire logic        ld_array_we_i,
    input  wire logic        ld_buffer_we_i,
    input  wire logic [8:0]  ld_page_i,
    input  wire logic [8:0]  ld_byte_i,
    input  wire logic [7:0]  ld_data_i,
    output logic             busy_o,
    output logic             cmp_mismatch_o
);
    import flash_rd_pkg::*;

    // ============================================================
    // Pin synchronisers and edge detection
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] si_sync_r;
    logic       cs_last_r;
    logic       sck_last_r;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cs_sync_r  <= 2'h3;
            sck_sync_r <= 2'h0;
            si_sync_r  <= 2'h0;
            cs_last_r  <= 1'b1;
            sck_last_r <= 1'b0;
        end else begin
            cs_sync_r  <= {cs_sync_r[0], spi.cs_n};
            sck_sync_r <= {sck_sync_r[0], spi.sck};
            si_sync_r  <= {si_sync_r[0], spi.si};
            cs_last_r  <= cs_sync_r[1];
            sck_last_r <= sck_sync_r[1];
        end
    end

    logic cs_low;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;

    // Mode 0 and mode 3 differ only in idle level, so edges alone drive the link
    assign cs_low   = !cs_sync_r[1];
    assign cs_rise  = cs_sync_r[1] && !cs_last_r;
    assign sck_rise = cs_low && sck_sync_r[1] && !sck_last_r;
    assign sck_fall = cs_low && !sck_sync_r[1] && sck_last_r;
    assign si_bit   = si_sync_r[1];

    // ============================================================
    // Storage: array and buffer
    logic [7:0] array_mem [ARRAY_BYTES];
    logic [7:0] buffer_mem [BYTES_PER_PAGE];

    // ============================================================
    // Frame decoder
    frame_phase_t phase_r;
    logic [5:0]   bit_cnt_r;
    logic [7:0]   op_r;
    logic [23:0]  addr_r;
    logic [8:0]   page_r;
    logic [8:0]   ptr_r;
    logic [2:0]   pos_r;
    logic         from_buf_r;
    logic         armed_r;
    logic         busy_r;
    logic [7:0]   op_nxt;
    logic [23:0]  addr_nxt;

    assign op_nxt   = {op_r[6:0], si_bit};
    assign addr_nxt = {addr_r[22:0], si_bit};

    function automatic logic [8:0] next_byte(input logic [8:0] cur);
        return (cur == LAST_BYTE) ? FIRST_BYTE : cur + 9'h001;
    endfunction : next_byte

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || !cs_low) begin
            phase_r    <= PH_OPCODE;
            bit_cnt_r  <= 6'h00;
            op_r       <= 8'h00;
            addr_r     <= 24'h000000;
            pos_r      <= 3'h0;
            from_buf_r <= 1'b0;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
            unique case (phase_r)
                PH_OPCODE: begin
                    op_r <= op_nxt;
                    if (bit_cnt_r == OPCODE_BITS - 6'h01) begin
                        bit_cnt_r <= 6'h00;
                        if (op_nxt == OP_STATUS_READ) begin
                            phase_r <= PH_STATUS;
                        end else if (busy_r) begin
                            phase_r <= PH_IGNORE;
                        end else if (op_nxt == OP_PAGE_READ || op_nxt == OP_BUF_READ ||
                                     op_nxt == OP_PAGE_TO_BUF || op_nxt == OP_PAGE_CMP) begin
                            phase_r <= PH_ADDR;
                        end else begin
                            phase_r <= PH_IGNORE;
                        end
                    end
                end
                PH_ADDR: begin
                    addr_r <= addr_nxt;
                    if (bit_cnt_r == ADDR_BITS - 6'h01) begin
                        bit_cnt_r  <= 6'h00;
                        page_r     <= addr_nxt[PAGE_FIELD_LSB +: 9];
                        ptr_r      <= addr_nxt[BYTE_FIELD_LSB +: 9];
                        from_buf_r <= (op_r == OP_BUF_READ);
                        phase_r    <= (op_r == OP_PAGE_TO_BUF || op_r == OP_PAGE_CMP) ? PH_IGNORE : PH_DUMMY;
                    end
                end
                PH_DUMMY: begin
                    if (bit_cnt_r == (from_buf_r ? BUF_READ_DUMMY : PAGE_READ_DUMMY) - 6'h01) begin
                        phase_r <= PH_DATA;
                    end
                end
                PH_DATA, PH_STATUS, PH_IGNORE: begin
                end
            endcase
        end else if (sck_fall && (phase_r == PH_DATA || phase_r == PH_STATUS)) begin
            pos_r <= pos_r + 3'h1;
            if (pos_r == 3'h7 && phase_r == PH_DATA) begin
                ptr_r <= next_byte(ptr_r);
            end
        end
    end

    // Transfer or compare request stays armed until the frame closes
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || cs_rise) begin
            armed_r <= 1'b0;
        end else if (sck_rise && phase_r == PH_ADDR && bit_cnt_r == ADDR_BITS - 6'h01) begin
            armed_r <= (op_r == OP_PAGE_TO_BUF || op_r == OP_PAGE_CMP);
        end
    end

    // ============================================================
    // Serial output
    logic [7:0] status_byte;
    logic [7:0] stat_lat_r;
    logic [7:0] data_byte;
    logic [7:0] out_byte;
    logic       so_r;
    logic       so_oe_r;
    logic       cmp_r;

    assign status_byte = {!busy_r, cmp_r, DENSITY_CODE, 2'h0};
    assign data_byte   = from_buf_r ? buffer_mem[ptr_r] : array_mem[mem_index(page_r, ptr_r)];
    assign out_byte    = (phase_r == PH_DATA) ? data_byte : ((pos_r == 3'h0) ? status_byte : stat_lat_r);

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || !cs_low) begin
            so_r       <= 1'b1;
            so_oe_r    <= 1'b0;
            stat_lat_r <= 8'h00;
        end else if (sck_fall && (phase_r == PH_DATA || phase_r == PH_STATUS)) begin
            so_r    <= out_byte[3'h7 - pos_r];
            so_oe_r <= 1'b1;
            if (pos_r == 3'h0) begin
                stat_lat_r <= status_byte;
            end
        end
    end

    assign spi.so_drv = so_r;
    assign spi.so_oe  = so_oe_r;

    // ============================================================
    // Background transfer and compare engine
    engine_state_t eng_r;
    logic [8:0]    eng_idx_r;
    logic [8:0]    eng_page_r;
    logic [15:0]   eng_time_r;
    logic          diff_r;
    logic          scan_done_r;
    logic [7:0]    eng_arr_byte;

    assign eng_arr_byte = array_mem[mem_index(eng_page_r, eng_idx_r)];

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            eng_r       <= ENG_IDLE;
            busy_r      <= 1'b0;
            cmp_r       <= CMP_RESET;
            eng_idx_r   <= 9'h000;
            eng_page_r  <= 9'h000;
            eng_time_r  <= 16'h0000;
            diff_r      <= 1'b0;
            scan_done_r <= 1'b0;
        end else begin
            unique case (eng_r)
                ENG_IDLE: begin
                    if (cs_rise && armed_r) begin
                        eng_r       <= (op_r == OP_PAGE_CMP) ? ENG_CMP : ENG_COPY;
                        busy_r      <= 1'b1;
                        eng_page_r  <= page_r;
                        eng_idx_r   <= 9'h000;
                        eng_time_r  <= 16'h0000;
                        diff_r      <= 1'b0;
                        scan_done_r <= 1'b0;
                    end
                end
                ENG_COPY, ENG_CMP: begin
                    eng_time_r <= eng_time_r + 16'h0001;
                    if (!scan_done_r) begin
                        if (eng_r == ENG_CMP && eng_arr_byte != buffer_mem[eng_idx_r]) begin
                            diff_r <= 1'b1;
                        end
                        eng_idx_r   <= next_byte(eng_idx_r);
                        scan_done_r <= (eng_idx_r == LAST_BYTE);
                    end else if (eng_time_r >= 16'(PAGE_TRANSFER_CYC - 1)) begin
                        // Busy spans the whole page transfer time, not just the scan
                        eng_r  <= ENG_IDLE;
                        busy_r <= 1'b0;
                        if (eng_r == ENG_CMP) begin
                            cmp_r <= diff_r;
                        end
                    end
                end
            endcase
        end
    end

    // Buffer written only by the copy engine and the load port
    always_ff @(posedge core_clk_i) begin
        if (eng_r == ENG_COPY && !scan_done_r) begin
            buffer_mem[eng_idx_r] <= eng_arr_byte;
        end else if (ld_buffer_we_i && ld_byte_i <= LAST_BYTE) begin
            buffer_mem[ld_byte_i] <= ld_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ld_array_we_i && ld_byte_i <= LAST_BYTE) begin
            array_mem[mem_index(ld_page_i, ld_byte_i)] <= ld_data_i;
        end
    end

    assign busy_o         = busy_r;
    assign cmp_mismatch_o = cmp_r;
endmodule : flash_rd_device

// file: logic/flash_rd_host.sv
// Host end: SPI master in mode 0 that issues one framed instruction per start
`timescale 1ns/10ps
module flash_rd_host (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    flash_spi_if.host        spi,
    input  wire logic        start_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [9:0]  rd_bytes_i,
    output logic             ready_o,
    output logic [7:0]       rd_data_o,
    output logic             rd_valid_o,
    output logic             done_o
);
    import flash_rd_pkg::*;

    // ============================================================
    // Output line synchroniser
    logic [1:0] so_sync_r;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            so_sync_r <= 2'h3;
        end else begin
            so_sync_r <= {so_sync_r[0], spi.so};
        end
    end

    // ============================================================
    // Clock divider and sequencer
    host_state_t state_r;
    logic [7:0]  div_r;
    logic        tick;
    logic        cs_n_r;
    logic        sck_r;
    logic [63:0] tx_r;
    logic [7:0]  rx_r;
    logic [13:0] bit_cnt_r;
    logic [13:0] tx_bits_r;
    logic [13:0] total_r;
    logic [13:0] rx_idx;
    logic [5:0]  dummy;

    assign tick   = (div_r == 8'(SCK_HALF_CYC - 1));
    assign rx_idx = bit_cnt_r - tx_bits_r;
    assign dummy  = (opcode_i == OP_PAGE_READ) ? PAGE_READ_DUMMY :
                    (opcode_i == OP_BUF_READ)  ? BUF_READ_DUMMY  : 6'h00;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || state_r == HS_IDLE || tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_r    <= HS_IDLE;
            cs_n_r     <= 1'b1;
            sck_r      <= 1'b0;
            tx_r       <= 64'h0;
            rx_r       <= 8'h00;
            bit_cnt_r  <= 14'h0000;
            tx_bits_r  <= 14'h0000;
            total_r    <= 14'h0000;
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
            done_o     <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            done_o     <= 1'b0;
            unique case (state_r)
                HS_IDLE: begin
                    if (start_i) begin
                        state_r   <= HS_RUN;
                        cs_n_r    <= 1'b0;
                        sck_r     <= 1'b0;
                        tx_r      <= {opcode_i, addr_i, 32'h0};
                        bit_cnt_r <= 14'h0000;
                        // Status read carries no address field
                        tx_bits_r <= (opcode_i == OP_STATUS_READ) ? 14'(OPCODE_BITS) :
                                     14'(OPCODE_BITS) + 14'(ADDR_BITS) + 14'(dummy);
                        total_r   <= ((opcode_i == OP_STATUS_READ) ? 14'(OPCODE_BITS) :
                                     14'(OPCODE_BITS) + 14'(ADDR_BITS) + 14'(dummy)) +
                                     ((opcode_i == OP_PAGE_READ || opcode_i == OP_BUF_READ ||
                                       opcode_i == OP_STATUS_READ) ? {1'b0, rd_bytes_i, 3'h0} : 14'h0000);
                    end
                end
                HS_RUN: begin
                    if (tick) begin
                        if (!sck_r) begin
                            if (bit_cnt_r == total_r) begin
                                state_r <= HS_FINISH;
                                cs_n_r  <= 1'b1;
                            end else begin
                                sck_r     <= 1'b1;
                                bit_cnt_r <= bit_cnt_r + 14'h0001;
                                if (bit_cnt_r >= tx_bits_r) begin
                                    rx_r <= {rx_r[6:0], so_sync_r[1]};
                                    if (rx_idx[2:0] == 3'h7) begin
                                        rd_data_o  <= {rx_r[6:0], so_sync_r[1]};
                                        rd_valid_o <= 1'b1;
                                    end
                                end
                            end
                        end else begin
                            sck_r <= 1'b0;
                            tx_r  <= {tx_r[62:0], 1'b0};
                        end
                    end
                end
                HS_FINISH: begin
                    // Chip select stays high one half period before the next frame
                    if (tick) begin
                        state_r <= HS_IDLE;
                        done_o  <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign spi.cs_n = cs_n_r;
    assign spi.sck  = sck_r;
    assign spi.si   = tx_r[63];
    assign ready_o  = (state_r == HS_IDLE);
endmodule : flash_rd_host

// file: testbench/flash_rd_assertions.sv
// Checker on the serial link between the flash device end and the host end
`timescale 1ns/10ps
module flash_rd_assertions (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_drv,
    input wire logic so_oe,
    input wire logic so
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // ============================================================
    // Sequences
    sequence s_sck_high;
        sck [*8] ##1 !sck;
    endsequence
    sequence s_released;
        ##[1:4] !so_oe;
    endsequence
    sequence s_frame_open;
        !sck [*8] ##1 sck;
    endsequence

    // ============================================================
    // Link rules
    a_sck_high_span: assert property ($rose(sck) |-> s_sck_high)
        else $error("serial clock high phase is not 8 cycles");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock not low outside a frame");
    a_si_stable_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    a_so_release: assert property ($rose(cs_n) |-> s_released)
        else $error("output not released after chip select rise");
    a_so_idle_off: assert property (cs_n [*5] |-> !so_oe)
        else $error("output driven while deselected");
    a_so_start_low: assert property ($rose(so_oe) |-> !cs_n && !sck)
        else $error("output enabled outside a frame or with clock high");
    a_so_change_low: assert property ($changed(so_drv) && so_oe && $past(so_oe) |-> !sck)
        else $error("output bit changed while clock high");
    a_frame_open: assert property ($fell(cs_n) |-> s_frame_open)
        else $error("first serial clock rise not one half period after select");
    a_cs_close_quiet: assert property ($rose(cs_n) |-> !$past(sck, 8))
        else $error("chip select rose before the last clock low phase ended");
    a_so_idle_high: assert property (cs_n [*5] |-> so)
        else $error("output line not at pull-up level while deselected");
endmodule : flash_rd_assertions

// file: testbench/serial_flash_read_transfer_compare_tb.sv
// Testbench joining the device end and host end of the serial flash link
`timescale 1ns/10ps
module serial_flash_read_transfer_compare_tb;
    import flash_rd_pkg::*;
    logic        core_clk_i, resetn_i, start_i, ld_array_we_i, ld_buffer_we_i;
    logic        ready_o, rd_valid_o, done_o, busy_o, cmp_mismatch_o;
    logic [7:0]  opcode_i, ld_data_i, rd_data_o;
    logic [8:0]  ld_page_i, ld_byte_i;
    logic [9:0]  rd_bytes_i;
    logic [23:0] addr_i;
    logic [7:0]  got [$];
    int          num_errors, num_checks;

    flash_spi_if spi_bus ();
    flash_rd_device u_flash_rd_device (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .spi(spi_bus.dev),
        .ld_array_we_i(ld_array_we_i), .ld_buffer_we_i(ld_buffer_we_i), .ld_page_i(ld_page_i),
        .ld_byte_i(ld_byte_i), .ld_data_i(ld_data_i), .busy_o(busy_o), .cmp_mismatch_o(cmp_mismatch_o));
    flash_rd_host u_flash_rd_host (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .spi(spi_bus.host),
        .start_i(start_i), .opcode_i(opcode_i), .addr_i(addr_i), .rd_bytes_i(rd_bytes_i), .ready_o(ready_o),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o));
    flash_rd_assertions u_flash_rd_assertions (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .cs_n(spi_bus.cs_n), .sck(spi_bus.sck), .si(spi_bus.si), .so_drv(spi_bus.so_drv),
        .so_oe(spi_bus.so_oe), .so(spi_bus.so));

    // ============================================================
    // Helpers
    function automatic logic [7:0] arr_val(input int p, input int b);
        return 8'((b + p * 3) ^ 8'h5a);
    endfunction : arr_val

    function automatic logic [7:0] stat(input logic rdy, input logic cmp);
        return {rdy, cmp, DENSITY_CODE, 2'h0};
    endfunction : stat

    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        num_checks++;
        if (got_v !== exp_v) begin
            num_errors++;
            $display("BAD %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : chk

    // Preload through the side port, standing in for the write path
    task automatic load(input logic to_buf, input int p);
        for (int b = 0; b < BYTES_PER_PAGE; b++) begin
            @(negedge core_clk_i);
            ld_array_we_i = !to_buf;
            ld_buffer_we_i = to_buf;
            ld_page_i = 9'(p);
            ld_byte_i = 9'(b);
            ld_data_i = to_buf ? (8'(b) ^ 8'ha5) : arr_val(p, b);
        end
        @(negedge core_clk_i);
        ld_array_we_i = 1'b0;
        ld_buffer_we_i = 1'b0;
    endtask : load

    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int n);
        int guard;
        got.delete();
        @(negedge core_clk_i);
        chk(ready_o, 1'b1);
        start_i = 1'b1;
        opcode_i = op;
        addr_i = addr;
        rd_bytes_i = 10'(n);
        @(negedge core_clk_i);
        start_i = 1'b0;
        guard = 0;
        while (done_o !== 1'b1 && guard < 4000) begin
            @(negedge core_clk_i);
            if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
            guard++;
        end
        // A frame that never closes counts as a mismatch here
        chk(done_o, 1'b1);
        chk(8'(got.size()), 8'(n));
    endtask : frame

    // Bounded wait: engine holds busy for a fixed page transfer time
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
        chk(busy_o, 1'b0);
    endtask : wait_idle

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // ============================================================
    // Clock, watchdog and tests
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (60000) @(posedge core_clk_i);
        num_errors++;
        summarize();
    end

    initial begin
        {resetn_i, start_i, ld_array_we_i, ld_buffer_we_i} = 4'h0;
        {opcode_i, ld_data_i, ld_page_i, ld_byte_i, rd_bytes_i, addr_i} = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (20) @(negedge core_clk_i);
        resetn_i = 1'b1;
        load(1'b0, 5);
        load(1'b0, 6);
        load(1'b1, 0);
        frame(OP_PAGE_READ, {6'h00, 9'h005, 9'h106}, 4);
        for (int i = 0; i < 4; i++) chk(got[i], arr_val(5, (262 + i) % BYTES_PER_PAGE));
        frame(OP_BUF_READ, {15'h0000, 9'h107}, 3);
        for (int i = 0; i < 3; i++) chk(got[i], 8'((263 + i) % BYTES_PER_PAGE) ^ 8'ha5);
        frame(OP_STATUS_READ, 24'h000000, 2);
        for (int i = 0; i < 2; i++) chk(got[i], stat(1'b1, 1'b0));
        frame(OP_PAGE_TO_BUF, {6'h00, 9'h005, 9'h000}, 0);
        chk(busy_o, 1'b1);
        frame(OP_STATUS_READ, 24'h000000, 1);
        chk(got[0], stat(1'b0, 1'b0));
        wait_idle();
        frame(OP_BUF_READ, 24'h000000, 2);
        for (int i = 0; i < 2; i++) chk(got[i], arr_val(5, i));
        for (int k = 0; k < 3; k++) begin
            // Last pass spoils only the final buffer byte, so a short scan would miss it
            if (k == 2) begin
                @(negedge core_clk_i);
                ld_buffer_we_i = 1'b1;
                ld_byte_i = LAST_BYTE;
                ld_data_i = ~arr_val(5, 263);
                @(negedge core_clk_i);
                ld_buffer_we_i = 1'b0;
            end
            frame(OP_PAGE_CMP, {6'h00, ((k == 0) ? 9'h006 : 9'h005), 9'h000}, 0);
            chk(busy_o, 1'b1);
            frame(OP_STATUS_READ, 24'h000000, 1);
            chk(got[0] & 8'h80, 8'h00);
            wait_idle();
            chk(cmp_mismatch_o, k != 1);
            frame(OP_STATUS_READ, 24'h000000, 1);
            chk(got[0], stat(1'b1, k != 1));
        end
        summarize();
    end
endmodule : serial_flash_read_transfer_compare_tb
